// ==== design/mics_ctl.sv ====
// Management interrupt and clock stop controller
`timescale 1ns/1ps
`default_nettype none
module mics_ctl
  import mics_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_sys_mgmt_irq_n,
  input wire logic i_clock_stop_req_n,
  input wire logic i_sleep_req_n,
  input wire logic i_state_saved,
  input wire logic i_ack_done,
  input wire logic i_rsm,
  output mics_clk_ctl_type o_clk_ctl,
  output mics_ack_type o_ack,
  output logic o_save_req,
  output logic o_system_management_mode,
  output logic o_handler_start,
  output logic o_outputs_oe_n,
  output mics_state_type o_state
);

  // ***********************************************************
  // Input synchronisers
  // ***********************************************************
  logic smi_n_s;
  logic stop_n_s;
  logic sleep_n_s;

  // Asynchronous pins are never read raw by the state machine; only the reset-release strap samples i_sys_mgmt_irq_n raw
  mics_sync #(.STAGES(MICS_SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_smi (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(i_sys_mgmt_irq_n),
    .o_sync(smi_n_s)
  );
  mics_sync #(.STAGES(MICS_SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_stop (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(i_clock_stop_req_n),
    .o_sync(stop_n_s)
  );
  mics_sync #(.STAGES(MICS_SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_sleep (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(i_sleep_req_n),
    .o_sync(sleep_n_s)
  );

  // ***********************************************************
  // Reset-release strap
  // ***********************************************************
  logic first_q;
  logic hiz_q;

  // Caught on the first edge after release, never in the reset branch
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      first_q <= 1'b1;
      hiz_q <= 1'b1; // Float while in reset and until the strap is read
    end else if (first_q) begin
      first_q <= 1'b0;
      hiz_q <= ~i_sys_mgmt_irq_n;
    end
  end

  // Outputs float until the next reset once strapped
  assign o_outputs_oe_n = hiz_q;

  // ***********************************************************
  // Mode state machine
  // ***********************************************************
  mics_state_type state_q;
  mics_state_type state_d;

  // Management interrupt wins over stop request when both arrive
  always_comb begin
    state_d = state_q;
    case (state_q)
      MICS_ST_RUN: begin
        if (first_q || hiz_q) begin
          state_d = MICS_ST_RUN;
        end else if (!smi_n_s) begin
          state_d = MICS_ST_SAVE;
        end else if (!stop_n_s) begin
          state_d = MICS_ST_STOP_ACK;
        end
      end
      MICS_ST_SAVE: begin
        if (i_state_saved) begin
          state_d = MICS_ST_SMM_ACK;
        end
      end
      MICS_ST_SMM_ACK: begin
        if (i_ack_done) begin
          state_d = MICS_ST_SMM_HANDLER;
        end
      end
      MICS_ST_SMM_HANDLER: begin
        if (i_rsm) begin
          state_d = MICS_ST_RUN;
        end
      end
      MICS_ST_STOP_ACK: begin
        if (i_ack_done) begin
          state_d = MICS_ST_STOP_GRANT;
        end
      end
      MICS_ST_STOP_GRANT: begin
        if (stop_n_s) begin
          state_d = MICS_ST_RUN;
        end else if (!sleep_n_s) begin
          state_d = MICS_ST_SLEEP;
        end
      end
      MICS_ST_SLEEP: begin
        if (sleep_n_s) begin
          state_d = MICS_ST_STOP_GRANT;
        end
      end
      default: begin
        state_d = MICS_ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= MICS_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ***********************************************************
  // Registered outputs
  // ***********************************************************
  mics_clk_ctl_type clk_q;
  mics_ack_type ack_q;
  logic save_q;
  logic smm_q;
  logic start_q;

  // Clock gating follows the next state so gates move with the state
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_q <= '1;
    end else begin
      case (state_d)
        MICS_ST_STOP_GRANT, MICS_ST_STOP_ACK: begin
          clk_q <= '{core_clk_en: 1'b0, bus_clk_en: 1'b1, irq_unit_clk_en: 1'b1,
                     snoop_en: 1'b1, irq_service_en: 1'b1};
        end
        MICS_ST_SLEEP: begin
          clk_q <= '0;
        end
        default: begin
          clk_q <= '1;
        end
      endcase
    end
  end

  // Acknowledge held until the bus unit reports it issued
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_q <= '{valid: 1'b0, kind: MICS_ACK_NONE};
    end else if (state_d == MICS_ST_SMM_ACK) begin
      ack_q <= '{valid: 1'b1, kind: MICS_ACK_SMI};
    end else if (state_d == MICS_ST_STOP_ACK) begin
      ack_q <= '{valid: 1'b1, kind: MICS_ACK_STOP_GRANT};
    end else begin
      ack_q <= '{valid: 1'b0, kind: MICS_ACK_NONE};
    end
  end

  // Mode flags and handler start pulse
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      save_q <= 1'b0;
      smm_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      save_q <= (state_d == MICS_ST_SAVE);
      smm_q <= (state_d == MICS_ST_SMM_ACK) || (state_d == MICS_ST_SMM_HANDLER);
      start_q <= (state_q == MICS_ST_SMM_ACK) && (state_d == MICS_ST_SMM_HANDLER);
    end
  end

  assign o_clk_ctl = clk_q;
  assign o_ack = ack_q;
  assign o_save_req = save_q;
  assign o_system_management_mode = smm_q;
  assign o_handler_start = start_q;
  assign o_state = state_q;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  AST_SAVE_BEFORE_SMM: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (state_q == MICS_ST_SAVE && !i_state_saved) |=> !o_system_management_mode)
    else $error("Management mode entered before state saved");

  AST_SMI_ACK: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (state_q == MICS_ST_SAVE && i_state_saved) |=> (o_ack.valid && o_ack.kind == MICS_ACK_SMI))
    else $error("No management acknowledge after save");

  AST_HANDLER_AFTER_ACK: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_handler_start |-> $past(o_ack.valid) && $past(o_ack.kind) == MICS_ACK_SMI)
    else $error("Handler started without acknowledge");

  AST_HIZ_STRAP: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (first_q && !i_sys_mgmt_irq_n) |=> o_outputs_oe_n [*3])
    else $error("Outputs not floated after strap");

  AST_STOP_ENTRY: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (state_q == MICS_ST_RUN && !first_q && !hiz_q && smi_n_s && !stop_n_s)
      |=> (o_ack.kind == MICS_ACK_STOP_GRANT && !o_clk_ctl.core_clk_en))
    else $error("Stop request did not start stop-grant");

  AST_GRANT_CLOCKS: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (state_q == MICS_ST_STOP_GRANT) |-> (!o_clk_ctl.core_clk_en && o_clk_ctl.bus_clk_en
      && o_clk_ctl.irq_unit_clk_en && o_clk_ctl.snoop_en && o_clk_ctl.irq_service_en))
    else $error("Stop-grant clock gating wrong");

  AST_RESUME: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (state_q == MICS_ST_STOP_GRANT && stop_n_s) |=> (o_clk_ctl == '1 && state_q == MICS_ST_RUN))
    else $error("No resume after stop release");

  AST_SLEEP_ONLY_FROM_GRANT: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (state_q == MICS_ST_SLEEP && $past(state_q) != MICS_ST_SLEEP)
      |-> $past(state_q) == MICS_ST_STOP_GRANT)
    else $error("Sleep entered from wrong state");

  AST_SLEEP_EXIT: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (state_q == MICS_ST_SLEEP && sleep_n_s) |=> (state_q == MICS_ST_STOP_GRANT
      && o_clk_ctl.bus_clk_en))
    else $error("Sleep release did not return to stop-grant");

  AST_SYNC_DELAY: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $fell(i_clock_stop_req_n) |-> ##2 stop_n_s ##1 !stop_n_s)
    else $error("Stop input synchroniser latency wrong");

endmodule : mics_ctl
`default_nettype wire

// ==== design/mics_pkg.sv ====
// Package for the management interrupt and clock stop controller
package mics_pkg;

  // ***********************************************************
  // Synchroniser and sequencing constants
  // ***********************************************************
  localparam int unsigned MICS_SYNC_STAGES = 3;
  localparam logic [1:0] MICS_RST_OUT_HIZ = 2'h0;

  // Bus acknowledge transaction codes
  localparam logic [1:0] MICS_ACK_NONE = 2'h0;
  localparam logic [1:0] MICS_ACK_SMI = 2'h1;
  localparam logic [1:0] MICS_ACK_STOP_GRANT = 2'h2;

  // Power and mode state machine
  typedef enum logic [2:0] {
    MICS_ST_RUN = 3'b000,
    MICS_ST_SAVE = 3'b001,
    MICS_ST_SMM_ACK = 3'b010,
    MICS_ST_SMM_HANDLER = 3'b011,
    MICS_ST_STOP_ACK = 3'b100,
    MICS_ST_STOP_GRANT = 3'b101,
    MICS_ST_SLEEP = 3'b110
  } mics_state_type;

  // Clock gate controls, travel together
  typedef struct packed {
    logic core_clk_en;
    logic bus_clk_en;
    logic irq_unit_clk_en;
    logic snoop_en;
    logic irq_service_en;
  } mics_clk_ctl_type;

  // Acknowledge request toward the bus unit
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
  } mics_ack_type;

endpackage : mics_pkg

// ==== design/mics_sync.sv ====
// Multi-stage level synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module mics_sync
  import mics_pkg::*;
#(
  parameter int unsigned STAGES = MICS_SYNC_STAGES,
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_sync
);

  logic [STAGES-1:0] chain_q;

  // Shift chain; only the last stage is read outside
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chain_q <= {STAGES{RESET_VAL}};
    end else begin
      chain_q <= {chain_q[STAGES-2:0], i_async};
    end
  end

  assign o_sync = chain_q[STAGES-1];

endmodule : mics_sync
`default_nettype wire

// ==== tb/mgmt_interrupt_clock_stop_ctl_tb.sv ====
// Self-checking testbench for the management interrupt and clock stop controller
`timescale 1ns/1ps
`default_nettype none
module mgmt_interrupt_clock_stop_ctl_tb
  import mics_pkg::*;
;
  logic clk, nrst, irq_n, stop_n, sleep_n, slow, saved, ack_done, rsm;
  logic save_req, system_management_mode, hstart, oe_n;
  mics_clk_ctl_type clk_ctl;
  mics_ack_type ack;
  mics_state_type state;
  int mismatches, samples_checked;

  mics_ctl DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_sys_mgmt_irq_n(irq_n),
    .i_clock_stop_req_n(stop_n), .i_sleep_req_n(sleep_n), .i_state_saved(saved),
    .i_ack_done(ack_done), .i_rsm(rsm), .o_clk_ctl(clk_ctl), .o_ack(ack),
    .o_save_req(save_req), .o_system_management_mode(system_management_mode), .o_handler_start(hstart),
    .o_outputs_oe_n(oe_n), .o_state(state));
  mics_sys_model partner (.i_ref_clk(clk), .i_nrst(nrst), .i_slow(slow),
    .i_save_req(save_req), .i_ack(ack), .i_handler_start(hstart),
    .o_state_saved(saved), .o_ack_done(ack_done), .o_rsm(rsm));

  // ***************************************************
  // Clock, compare and verdict
  // ***************************************************
  // Free-running bus clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Bounded wait; a hang is cut short and reported
  task wait_st(input mics_state_type s);
    int n;
    for (n = 0; n < 20 && state !== s; n++) @(negedge clk);
    if (state !== s) begin
      mismatches++;
      $display("ERROR %0t: state wait timed out", $time);
      give_verdict();
    end
  endtask : wait_st

  task do_reset(input logic irq);
    nrst = 1'b0;
    irq_n = irq;
    stop_n = 1'b1;
    sleep_n = 1'b1;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset

  // ***************************************************
  // Scenarios
  // ***************************************************
  task test_reset;
    check(clk_ctl, 8'h1F);
    check(oe_n, 1'b0);
    check(state, MICS_ST_RUN);
    $display("test reset done");
  endtask : test_reset

  task test_sleep_refused;
    sleep_n = 1'b0;
    repeat (8) @(negedge clk);
    check(state, MICS_ST_RUN);
    sleep_n = 1'b1;
    $display("test sleep refused done");
  endtask : test_sleep_refused

  task test_mgmt(input logic s);
    slow = s;
    irq_n = 1'b0;
    repeat (2) @(negedge clk);
    check(state, MICS_ST_RUN);
    wait_st(MICS_ST_SAVE);
    irq_n = 1'b1;
    check(save_req, 1'b1);
    check(system_management_mode, 1'b0);
    wait_st(MICS_ST_SMM_ACK);
    check(ack, {1'b1, MICS_ACK_SMI});
    check(system_management_mode, 1'b1);
    wait_st(MICS_ST_SMM_HANDLER);
    check(hstart, 1'b1);
    wait_st(MICS_ST_RUN);
    check(system_management_mode, 1'b0);
    $display("test mgmt done");
  endtask : test_mgmt

  task test_stop;
    stop_n = 1'b0;
    wait_st(MICS_ST_STOP_ACK);
    check(ack, {1'b1, MICS_ACK_STOP_GRANT});
    check(clk_ctl.core_clk_en, 1'b0);
    wait_st(MICS_ST_STOP_GRANT);
    check(clk_ctl, 8'h0F);
    check(ack, 3'h0);
    sleep_n = 1'b0;
    wait_st(MICS_ST_SLEEP);
    check(clk_ctl, 8'h00);
    sleep_n = 1'b1;
    wait_st(MICS_ST_STOP_GRANT);
    check(clk_ctl, 8'h0F);
    stop_n = 1'b1;
    wait_st(MICS_ST_RUN);
    check(clk_ctl, 8'h1F);
    $display("test stop done");
  endtask : test_stop

  task test_hiz;
    do_reset(1'b0);
    repeat (6) @(negedge clk);
    check(oe_n, 1'b1);
    check(state, MICS_ST_RUN);
    irq_n = 1'b1;
    repeat (6) @(negedge clk);
    check(oe_n, 1'b1);
    $display("test hiz done");
  endtask : test_hiz

  // Main sequence; the strap test goes last as its effect is sticky
  initial begin
    slow = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    do_reset(1'b1);
    test_reset();
    test_sleep_refused();
    test_mgmt(1'b0);
    test_mgmt(1'b1);
    test_stop();
    test_hiz();
    give_verdict();
  end
endmodule : mgmt_interrupt_clock_stop_ctl_tb
`default_nettype wire

// ==== tb/mics_sys_model.sv ====
// Behavioural model of the core and bus units answering the controller's handshakes
`timescale 1ns/1ps
`default_nettype none
module mics_sys_model
  import mics_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_slow,
  input wire logic i_save_req,
  input wire mics_ack_type i_ack,
  input wire logic i_handler_start,
  output logic o_state_saved,
  output logic o_ack_done,
  output logic o_rsm
);
  // ***************************************************
  // Handshake answers
  // ***************************************************
  logic [2:0] wait_q;
  logic handler_q;

  // Answers on the falling edge so the controller samples a settled level
  always_ff @(negedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_q <= 3'h0;
      handler_q <= 1'b0;
      o_state_saved <= 1'b0;
      o_ack_done <= 1'b0;
      o_rsm <= 1'b0;
    end else begin
      o_state_saved <= 1'b0;
      o_ack_done <= 1'b0;
      o_rsm <= 1'b0;
      if (i_handler_start) begin
        handler_q <= 1'b1; // Start is a pulse, so remember it
      end
      if (i_save_req || i_ack.valid || handler_q) begin
        // Slow mode stretches every answer to exercise the waits
        if (wait_q == (i_slow ? 3'h4 : 3'h0)) begin
          wait_q <= 3'h0;
          if (i_save_req) begin
            o_state_saved <= 1'b1;
          end else if (i_ack.valid) begin
            o_ack_done <= 1'b1;
          end else begin
            o_rsm <= 1'b1;
            handler_q <= 1'b0;
          end
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end
    end
  end
endmodule : mics_sys_model
`default_nettype wire
